// [mro_pkg.sv]
/*
 * Constants, field layout and carrier types for the first mode-register
 * group of a DRAM device: command pin bundle, state record, codes.
 * Assumes one command clock and that the pin bundle is sampled on it.
 */
//
// Behaviour
// - masking plus CRC: bad CRC drops write
// - DLL reset bit clears itself after use
// - mode set command, select 001 targets here
// - bit 12 disables drivers and termination
// - bit 11 enables extra strobe, x8 only
// - bits 10:8 select nominal termination value
// - bit 7 enters write leveling mode
// - bits 13,6,5 select receiver equalisation
// - bits 4:3 additive latency, 11 reserved
// - bits 2:1 select output driver impedance
// - bit 0 enables the DLL
// - self refresh turns DLL off, then on
// - writes need DLL only with store termination
// - store value during writes, parked when ODT low
package mro_pkg;

    // ------------------------------------------------------------
    // field layout of the mode word
    // ------------------------------------------------------------
    localparam int MR_W      = 22;
    localparam int B_RFU_HI  = 21;
    localparam int B_SEL_HI  = 20;
    localparam int B_SEL_LO  = 18;
    localparam int B_RFU_LO  = 17;
    localparam int B_RXEQ2   = 13;
    localparam int B_QOFF    = 12;
    localparam int B_EXTRA_TERMINATION_STROBE    = 11;
    localparam int B_NOM_HI  = 10;
    localparam int B_NOM_LO  = 8;
    localparam int B_WLEV    = 7;
    localparam int B_RXEQ1   = 6;
    localparam int B_RXEQ0   = 5;
    localparam int B_AL_HI   = 4;
    localparam int B_AL_LO   = 3;
    localparam int B_DRV_HI  = 2;
    localparam int B_DRV_LO  = 1;
    localparam int B_DLL     = 0;
    localparam int B_DLL_RST = 8;   // position in the group-zero word

    localparam logic [2:0]      SEL_MR0 = 3'h0;
    localparam logic [2:0]      SEL_MR1 = 3'h1;
    localparam logic [2:0]      SEL_DNU = 3'h7;
    localparam logic [MR_W-1:0] MR_RST  = 22'h000000;

    // ------------------------------------------------------------
    // codes and decoded values
    // ------------------------------------------------------------
    localparam logic [1:0] AL_RSVD = 2'h3;
    localparam logic [1:0] AL_M1   = 2'h1;
    localparam logic [1:0] DRV_34  = 2'h0;
    localparam logic [1:0] DRV_48  = 2'h1;
    localparam logic [1:0] DRV_40  = 2'h2;
    localparam logic [5:0] OHM_34  = 6'h22;
    localparam logic [5:0] OHM_48  = 6'h30;
    localparam logic [5:0] OHM_40  = 6'h28;
    localparam logic [2:0] NOM_OFF = 3'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int DLL_LOCK_CLKS = 1024;
    localparam int LOCK_W        = 11;

    typedef enum logic [1:0] {
        TS_OFF,
        TS_NOM,
        TS_STORE,
        TS_PARK
    } mro_term_e;

    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] addr;   // bits 16:14 double as the row/column/write strobes
    } mro_pins_s;

    typedef struct packed {
        mro_pins_s         pin1;
        mro_pins_s         pin2;
        logic              odt1;
        logic              odt2;
        logic [MR_W-1:0]   mr;
        logic              dll_rst;
        logic              sr;
        logic              dll_on;
        logic [LOCK_W-1:0] lock_cnt;
        logic              locked;
        logic              wr_store;
        logic              wr_drop;
        logic              wr_term_ok;
        logic              al_bad;
        logic [7:0]        nom_ohm;
        logic [5:0]        drv_ohm;
        mro_term_e         term_src;
    } mro_state_s;

endpackage

// [mro_core.sv]
/*
 * First mode-register group of the device: captures mode set commands
 * from the command pins, decodes the fields, runs the DLL reset and lock
 * wait, picks the live termination and gates writes on CRC results.
 * Assumes pins arrive asynchronous to clk_sys; the write, CRC and self
 * refresh strobes come from logic on clk_sys.
 */
`timescale 1ns/100ps
module mro_core #(
    parameter int DQ_WIDTH  = 8,                      // device data width
    parameter int LOCK_CLKS = mro_pkg::DLL_LOCK_CLKS  // DLL lock wait in clocks
) (
    input  wire logic                    clk_sys,      // command clock
    input  wire logic                    rstn,         // async reset, low
    input  wire mro_pkg::mro_pins_s      pins,         // command/address pins
    input  wire logic                    odt_pin,      // termination pin
    input  wire logic                    gear_down,    // quarter-rate mode on
    input  wire logic                    sr_enter,     // self refresh entry
    input  wire logic                    sr_exit,      // self refresh exit
    input  wire logic                    wr_phase,     // write burst active
    input  wire logic [2:0]              store_code,   // store-phase term code
    input  wire logic                    wr_req,       // write data complete
    input  wire logic                    crc_bad,      // CRC mismatch on it
    input  wire logic                    dm_en,        // data mask enabled
    input  wire logic                    crc_en,       // write CRC enabled
    output logic [mro_pkg::MR_W-1:0]     mode_word,    // stored register
    output logic                         output_off,   // drivers disabled
    output logic                         extra_termination_strobe_on,      // extra strobe active
    output logic [2:0]                   nominal_code, // nominal term code
    output logic [7:0]                   nominal_ohm,  // nominal term value
    output logic                         wl_mode,      // write leveling
    output logic [2:0]                   rx_eq,        // equaliser setting
    output logic [1:0]                   al_code,      // additive latency
    output logic                         al_bad,       // illegal latency code
    output logic [5:0]                   drv_ohm,      // driver impedance
    output logic                         dll_on,       // DLL running
    output logic                         dll_reset,    // DLL reset pulse
    output logic                         dll_locked,   // reads allowed
    output mro_pkg::mro_term_e           term_src,     // live termination
    output logic                         wr_term_ok,   // write term valid
    output logic                         wr_store,     // write committed
    output logic                         wr_drop       // write discarded
);

    localparam logic [mro_pkg::LOCK_W-1:0] LOCK_LAST =
        mro_pkg::LOCK_W'(LOCK_CLKS - 1);

    mro_pkg::mro_state_s st_reg;
    mro_pkg::mro_state_s st_next;
    logic [mro_pkg::MR_W-1:0] word;
    logic                     mrs;
    logic                     mrs_hit;
    logic                     mrs_mr0;
    logic                     crc_kill;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // only the second sync stage is looked at
    assign word = {st_reg.pin2.bg, st_reg.pin2.ba, st_reg.pin2.addr};
    assign mrs = !st_reg.pin2.cs_n && st_reg.pin2.act_n
        && (st_reg.pin2.addr[16:14] == 3'h0);
    assign mrs_hit = mrs
        && (word[mro_pkg::B_SEL_HI:mro_pkg::B_SEL_LO] == mro_pkg::SEL_MR1);
    assign mrs_mr0 = mrs
        && (word[mro_pkg::B_SEL_HI:mro_pkg::B_SEL_LO] == mro_pkg::SEL_MR0);
    assign crc_kill = dm_en && crc_en && crc_bad;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pin1 = pins;
        st_next.pin2 = st_reg.pin1;
        st_next.odt1 = odt_pin;
        st_next.odt2 = st_reg.odt1;
        st_next.dll_rst = 1'b0;
        st_next.wr_store = 1'b0;
        st_next.wr_drop = 1'b0;

        // reserved bits are stored as written; select 111 never matches
        if (mrs_hit) begin
            st_next.mr = word;
        end

        // reset bit is a one-cycle pulse, never held as state
        if (mrs_mr0 && word[mro_pkg::B_DLL_RST]) begin
            st_next.dll_rst = 1'b1;
        end

        // self refresh parks the DLL without touching the enable bit
        if (sr_enter) begin
            st_next.sr = 1'b1;
        end else if (sr_exit) begin
            st_next.sr = 1'b0;
        end
        st_next.dll_on = st_reg.mr[mro_pkg::B_DLL] && !st_next.sr;

        // lock wait restarts on every reset and on leaving self refresh
        if (st_reg.dll_rst || (sr_exit && st_reg.sr) || !st_reg.dll_on) begin
            st_next.lock_cnt = '0;
            st_next.locked = 1'b0;
        end else if (!st_reg.locked) begin
            if (st_reg.lock_cnt == LOCK_LAST) begin
                st_next.locked = 1'b1;
            end else begin
                st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
            end
        end

        // write commit or discard after the CRC verdict
        if (wr_req) begin
            st_next.wr_drop = crc_kill;
            st_next.wr_store = !crc_kill;
        end

        // store-phase termination is only trustworthy with the DLL running
        st_next.wr_term_ok = (store_code == 3'h0) || st_reg.dll_on;

        st_next.al_bad = (st_reg.mr[mro_pkg::B_AL_HI:mro_pkg::B_AL_LO] == mro_pkg::AL_RSVD)
            || (gear_down
            && st_reg.mr[mro_pkg::B_AL_HI:mro_pkg::B_AL_LO] == mro_pkg::AL_M1);

        // nominal termination value in ohms
        case (st_reg.mr[mro_pkg::B_NOM_HI:mro_pkg::B_NOM_LO])
            3'h1:    st_next.nom_ohm = 8'h3C;
            3'h2:    st_next.nom_ohm = 8'h78;
            3'h3:    st_next.nom_ohm = 8'h28;
            3'h4:    st_next.nom_ohm = 8'hF0;
            3'h5:    st_next.nom_ohm = 8'h30;
            3'h6:    st_next.nom_ohm = 8'h50;
            3'h7:    st_next.nom_ohm = 8'h22;
            default: st_next.nom_ohm = 8'h00;
        endcase

        // reserved 11 reads as zero ohms so nothing downstream trusts it
        case (st_reg.mr[mro_pkg::B_DRV_HI:mro_pkg::B_DRV_LO])
            mro_pkg::DRV_34: st_next.drv_ohm = mro_pkg::OHM_34;
            mro_pkg::DRV_48: st_next.drv_ohm = mro_pkg::OHM_48;
            mro_pkg::DRV_40: st_next.drv_ohm = mro_pkg::OHM_40;
            default:         st_next.drv_ohm = 6'h00;
        endcase

        // termination source, output disable overrides everything
        if (st_reg.mr[mro_pkg::B_QOFF]) begin
            st_next.term_src = mro_pkg::TS_OFF;
        end else if (wr_phase && store_code != 3'h0) begin
            st_next.term_src = mro_pkg::TS_STORE;
        end else if (!st_reg.odt2) begin
            st_next.term_src = mro_pkg::TS_PARK;
        end else if (st_reg.mr[mro_pkg::B_NOM_HI:mro_pkg::B_NOM_LO] != mro_pkg::NOM_OFF) begin
            st_next.term_src = mro_pkg::TS_NOM;
        end else begin
            st_next.term_src = mro_pkg::TS_OFF;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{pin1: '{cs_n: 1'b1, act_n: 1'b1, default: '0},
                        pin2: '{cs_n: 1'b1, act_n: 1'b1, default: '0},
                        mr: mro_pkg::MR_RST,
                        term_src: mro_pkg::TS_OFF,
                        default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from state bits
    // ------------------------------------------------------------
    assign mode_word    = st_reg.mr;
    assign output_off   = st_reg.mr[mro_pkg::B_QOFF];
    // a non-x8 part keeps the strobe pair quiet whatever is written
    assign extra_termination_strobe_on      = st_reg.mr[mro_pkg::B_EXTRA_TERMINATION_STROBE] && (DQ_WIDTH == 8);
    assign nominal_code = st_reg.mr[mro_pkg::B_NOM_HI:mro_pkg::B_NOM_LO];
    assign nominal_ohm  = st_reg.nom_ohm;
    assign wl_mode      = st_reg.mr[mro_pkg::B_WLEV];
    assign rx_eq        = {st_reg.mr[mro_pkg::B_RXEQ2], st_reg.mr[mro_pkg::B_RXEQ1],
                           st_reg.mr[mro_pkg::B_RXEQ0]};
    assign al_code      = st_reg.mr[mro_pkg::B_AL_HI:mro_pkg::B_AL_LO];
    assign al_bad       = st_reg.al_bad;
    assign drv_ohm      = st_reg.drv_ohm;
    assign dll_on       = st_reg.dll_on;
    assign dll_reset    = st_reg.dll_rst;
    assign dll_locked   = st_reg.locked;
    assign term_src     = st_reg.term_src;
    assign wr_term_ok   = st_reg.wr_term_ok;
    assign wr_store     = st_reg.wr_store;
    assign wr_drop      = st_reg.wr_drop;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    mrs_capture_a: assert property (mrs_hit |=> mode_word == $past(word))
        else $error("mode set to group one not captured");
    dnu_ignore_a: assert property (mrs
        && word[mro_pkg::B_SEL_HI:mro_pkg::B_SEL_LO] == mro_pkg::SEL_DNU
        |=> $stable(mode_word))
        else $error("unused select changed the register");
    crc_drop_a: assert property (wr_req && crc_kill |=> wr_drop && !wr_store)
        else $error("bad CRC write was not dropped");
    crc_store_a: assert property (wr_req && !crc_kill |=> wr_store && !wr_drop)
        else $error("good write was not stored");
    // a second reset command right behind the first may legally re-raise it
    rst_self_clear_a: assert property (dll_reset
        && !(mrs_mr0 && word[mro_pkg::B_DLL_RST]) |=> !dll_reset && !dll_locked)
        else $error("DLL reset did not clear or lock held");
    sr_dll_off_a: assert property (sr_enter |=> !dll_on)
        else $error("DLL still on in self refresh");
    sr_dll_back_a: assert property (st_reg.sr && sr_exit && !sr_enter
        && mode_word[mro_pkg::B_DLL] && !mrs_hit |=> dll_on)
        else $error("DLL not back after self refresh");
    qoff_term_a: assert property (output_off |=> term_src == mro_pkg::TS_OFF)
        else $error("termination live with outputs disabled");
    park_term_a: assert property (!output_off && !st_reg.odt2
        && !(wr_phase && store_code != 3'h0) |=> term_src == mro_pkg::TS_PARK)
        else $error("parked termination not applied");
    store_dll_a: assert property (store_code != 3'h0 && !dll_on
        |=> !wr_term_ok)
        else $error("store termination claimed valid without DLL");
    al_gear_a: assert property (gear_down && al_code == mro_pkg::AL_M1
        |=> al_bad)
        else $error("latency minus one allowed in gear-down");
    lock_time_a: assert property ($rose(dll_locked)
        |-> $past(st_reg.lock_cnt) == LOCK_LAST)
        else $error("DLL lock flagged at wrong count");

    // ------------------------------------------------------------
    // checks on decoded values, one cycle behind the stored word
    // ------------------------------------------------------------
    // spot values of the termination table
    nom_off_a: assert property (nominal_code == 3'h0
        |=> nominal_ohm == 8'h00)
        else $error("nominal termination off still gave a value");
    nom_sixty_a: assert property (nominal_code == 3'h1
        |=> nominal_ohm == 8'h3C)
        else $error("nominal code one did not give 60 ohm");
    nom_max_a: assert property (nominal_code == 3'h4
        |=> nominal_ohm == 8'hF0)
        else $error("nominal code four did not give 240 ohm");
    nom_min_a: assert property (nominal_code == 3'h7
        |=> nominal_ohm == 8'h22)
        else $error("nominal code seven did not give 34 ohm");

    // driver impedance and latency codes, reserved ones included
    drv_strong_a: assert property (mode_word[mro_pkg::B_DRV_HI:mro_pkg::B_DRV_LO]
        == mro_pkg::DRV_34 |=> drv_ohm == mro_pkg::OHM_34)
        else $error("driver code zero did not give 34 ohm");
    drv_weak_a: assert property (mode_word[mro_pkg::B_DRV_HI:mro_pkg::B_DRV_LO]
        == mro_pkg::DRV_48 |=> drv_ohm == mro_pkg::OHM_48)
        else $error("driver code one did not give 48 ohm");
    drv_rsvd_a: assert property (mode_word[mro_pkg::B_DRV_HI:mro_pkg::B_DRV_LO]
        == 2'h3 |=> drv_ohm == 6'h00)
        else $error("reserved driver code gave a value");
    al_rsvd_a: assert property (al_code == mro_pkg::AL_RSVD
        |=> al_bad)
        else $error("reserved latency code not flagged");
    al_none_a: assert property (al_code == 2'h0
        |=> !al_bad)
        else $error("zero additive latency flagged as bad");

    // DLL enable, reset pulse and lock bookkeeping
    dll_bit_a: assert property (!mode_word[mro_pkg::B_DLL]
        |=> !dll_on)
        else $error("DLL running with its enable bit clear");
    rst_pulse_a: assert property (mrs_mr0 && word[mro_pkg::B_DLL_RST]
        |=> dll_reset)
        else $error("DLL reset command gave no pulse");
    rst_quiet_a: assert property (!(mrs_mr0 && word[mro_pkg::B_DLL_RST])
        |=> !dll_reset)
        else $error("DLL reset pulse without a command");
    lock_drop_a: assert property (!dll_on
        |=> !dll_locked)
        else $error("lock kept with the DLL stopped");
    lock_hold_a: assert property (dll_locked && dll_on && !dll_reset
        && !(st_reg.sr && sr_exit) |=> dll_locked)
        else $error("lock lost without a cause");
    sr_stay_a: assert property (st_reg.sr && !sr_exit
        |=> !dll_on)
        else $error("DLL running inside self refresh");

    // live termination source and its validity
    store_term_a: assert property (!output_off && wr_phase
        && store_code != 3'h0 |=> term_src == mro_pkg::TS_STORE)
        else $error("store termination not applied in a write");
    nom_term_a: assert property (!output_off && st_reg.odt2
        && !(wr_phase && store_code != 3'h0)
        && nominal_code != mro_pkg::NOM_OFF |=> term_src == mro_pkg::TS_NOM)
        else $error("nominal termination not applied");
    store_ok_a: assert property (dll_on
        |=> wr_term_ok)
        else $error("store termination refused with the DLL running");

    // write verdicts when the CRC gate is not armed, and no verdict without a request
    wr_plain_a: assert property (wr_req && !(dm_en && crc_en)
        |=> wr_store && !wr_drop)
        else $error("write dropped with the CRC gate disarmed");
    wr_idle_a: assert property (!wr_req
        |=> !wr_store && !wr_drop)
        else $error("write verdict without a request");

endmodule

// [mro_ctrl_model.sv]
/*
 * Behavioural controller on the far side of the command pins: issues mode
 * register set commands on request of the bench, idles deselected.
 * Assumes the bench calls mrs from one process at a time.
 */
`timescale 1ns/100ps
module mro_ctrl_model (
    input  wire logic          clk_sys, // command clock
    output mro_pkg::mro_pins_s pins     // command/address pins
);
    // ----------------------------------------------------------------
    // idle and command driving
    // ----------------------------------------------------------------
    // idle: deselected, address toggles so no stale value lingers
    initial begin
        pins = {1'b1, 1'b1, 22'h3FFFFF};
    end

    // one mode set: strobes low, reserved bits forced to zero
    task automatic mrs(input logic [2:0] sel, input logic [21:0] w);
        @(posedge clk_sys);
        #1;
        pins = {1'b0, 1'b1, 1'b0, sel, 1'b0, 3'h0, w[13:0]};
        @(posedge clk_sys);
        #1;
        pins = {1'b1, 1'b1, ~pins[21:0]};
    endtask
endmodule

// [sdram_mode_reg_one_dll_ctrl_tb_top.sv]
/*
 * Self-checking bench for the first mode-register group: fields, selects,
 * DLL reset and lock, self refresh, write CRC gating and termination.
 * Assumes mro_core and the controller model are compiled beforehand.
 */
`timescale 1ns/100ps
module sdram_mode_reg_one_dll_ctrl_tb_top;
    localparam int LOCK = 8;   // shortened lock wait keeps the run brief
    logic               clk_sys, rstn, odt_pin, gear_down, sr_enter, sr_exit;
    logic               wr_phase, wr_req, crc_bad, dm_en, crc_en;
    logic [2:0]         store_code, nominal_code, rx_eq;
    mro_pkg::mro_pins_s pins;
    logic [21:0]        mode_word, w;
    logic [7:0]         nominal_ohm;
    logic [5:0]         drv_ohm;
    logic [1:0]         al_code;
    logic               output_off, extra_termination_strobe_on, wl_mode, al_bad, dll_on, dll_reset;
    logic               dll_locked, wr_term_ok, wr_store, wr_drop, s1, d1;
    mro_pkg::mro_term_e term_src;
    int                 err_count, total_checks, n;
    logic [7:0]         ohm [8] = '{8'h00, 8'h3C, 8'h78, 8'h28, 8'hF0, 8'h30, 8'h50, 8'h22};
    logic [5:0]         drv [4] = '{6'h22, 6'h30, 6'h28, 6'h00};

    mro_ctrl_model ctrl_u (.clk_sys(clk_sys), .pins(pins));

    mro_core #(.LOCK_CLKS(LOCK)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .pins(pins), .odt_pin(odt_pin),
        .gear_down(gear_down), .sr_enter(sr_enter), .sr_exit(sr_exit),
        .wr_phase(wr_phase), .store_code(store_code), .wr_req(wr_req),
        .crc_bad(crc_bad), .dm_en(dm_en), .crc_en(crc_en), .mode_word(mode_word),
        .output_off(output_off), .extra_termination_strobe_on(extra_termination_strobe_on), .nominal_code(nominal_code),
        .nominal_ohm(nominal_ohm), .wl_mode(wl_mode), .rx_eq(rx_eq), .al_code(al_code),
        .al_bad(al_bad), .drv_ohm(drv_ohm), .dll_on(dll_on), .dll_reset(dll_reset),
        .dll_locked(dll_locked), .term_src(term_src), .wr_term_ok(wr_term_ok),
        .wr_store(wr_store), .wr_drop(wr_drop));

    // ----------------------------------------------------------------
    // clock, helpers
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // inputs move 1 ns after the edge, never racing the sampling edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_t(input mro_pkg::mro_term_e got, input mro_pkg::mro_term_e exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t term got %h exp %h", $time, got, exp);
        end
    endtask

    // mode set then let sync, decode and the decoded values land
    task automatic mset(input logic [2:0] sel, input logic [21:0] v);
        ctrl_u.mrs(sel, v);
        tick(5);
    endtask

    task automatic term(input logic o, input logic p, input logic [2:0] c);
        odt_pin = o;
        wr_phase = p;
        store_code = c;
        tick(5);
    endtask

    // bound exceeded counts as a mismatch
    task automatic wait_lock;
        n = 0;
        while (dll_locked !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk(n >= LOCK - 3 && n <= LOCK + 3, 1);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn, odt_pin, gear_down, sr_enter, sr_exit, wr_phase, wr_req} = '0;
        {crc_bad, dm_en, crc_en, store_code, err_count, total_checks} = '0;
        tick(8);
        rstn = 1'b1;
        tick(1);
        chk(mode_word, 22'h0);
        chk_t(term_src, mro_pkg::TS_PARK);
        $display("test reset done");
        // every code of every field except output disable (bit 12 held low), DLL kept off
        for (int i = 0; i < 8; i++) begin
            w = 22'h040000;
            w[13] = i[2];
            w[6:5] = i[1:0];
            w[10:8] = i[2:0];
            w[4:3] = i[1:0];
            w[2:1] = i[1:0];
            w[11] = i[0];
            w[7] = i[1];
            gear_down = i[2];
            mset(3'h1, w);
            chk(mode_word, w);
            chk(nominal_code, i);
            chk(nominal_ohm, ohm[i]);
            chk(extra_termination_strobe_on, i[0]);
            chk(wl_mode, i[1]);
            chk(rx_eq, i);
            chk(al_code, i[1:0]);
            chk(al_bad, i[1:0] == 2'h3 || i == 5);
            chk(drv_ohm, drv[i[1:0]]);
            chk(output_off, 0);
        end
        mset(3'h7, 22'h0);
        mset(3'h2, 22'h0);
        chk(mode_word, w);
        $display("test fields done");
        term(1, 0, 0);
        chk_t(term_src, mro_pkg::TS_NOM);
        term(1, 1, 2);
        chk_t(term_src, mro_pkg::TS_STORE);
        chk(wr_term_ok, 0);
        term(0, 0, 0);
        chk_t(term_src, mro_pkg::TS_PARK);
        mset(3'h1, 22'h041700);
        chk(output_off, 1);
        chk_t(term_src, mro_pkg::TS_OFF);
        mset(3'h1, 22'h040000);
        term(1, 0, 0);
        chk_t(term_src, mro_pkg::TS_OFF);
        $display("test termination done");
        mset(3'h1, 22'h040001);
        chk(dll_on, 1);
        chk(dll_locked, 0);
        ctrl_u.mrs(3'h0, 22'h000100);
        n = 0;
        while (dll_reset !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk(n < 10, 1);
        tick(1);
        chk(dll_reset, 0);
        wait_lock();
        term(1, 1, 2);
        chk(wr_term_ok, 1);
        sr_enter = 1'b1;
        tick(1);
        sr_enter = 1'b0;
        tick(1);
        chk(dll_on, 0);
        sr_exit = 1'b1;
        tick(1);
        sr_exit = 1'b0;
        tick(1);
        chk(dll_on, 1);
        chk(dll_locked, 0);
        wait_lock();
        $display("test dll done");
        for (int j = 0; j < 8; j++) begin
            {dm_en, crc_en, crc_bad} = j[2:0];
            wr_req = 1'b1;
            tick(1);
            // verdict pulse stands only in the cycle after the request edge
            {s1, d1} = {wr_store, wr_drop};
            wr_req = 1'b0;
            tick(1);
            chk(s1, j != 7);
            chk(d1, j == 7);
            chk({wr_store, wr_drop}, 0);
        end
        $display("test writes done");
        give_verdict();
    end
endmodule
